// [icdp_pkg.sv]
// constants shared by the input clock divider phase block
package icdp_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [9:0]  IDX_RATIO = 10'h108;
	localparam logic [9:0]  IDX_PHASE = 10'h109;
	localparam logic [9:0]  IDX_SREF  = 10'h10a;
	localparam logic [9:0]  IDX_CAPT  = 10'h129;
	localparam logic [11:0] ADDR_RATIO = {IDX_RATIO, 2'b00};
	localparam logic [11:0] ADDR_PHASE = {IDX_PHASE, 2'b00};
	localparam logic [11:0] ADDR_SREF  = {IDX_SREF, 2'b00};
	localparam logic [11:0] ADDR_CAPT  = {IDX_CAPT, 2'b00};
	// field positions
	localparam int RATIO_LSB  = 0;
	localparam int PHASE_LSB  = 0;
	localparam int AUTO_BIT   = 7;
	localparam int NEG_LSB    = 2;
	localparam int POS_LSB    = 0;
	localparam int CAPT_LSB   = 0;
	// reset values
	localparam logic [2:0] RATIO_RST = 3'h0;
	localparam logic [3:0] PHASE_RST = 4'h0;
	localparam logic       AUTO_RST  = 1'b0;
	localparam logic [1:0] SKEW_RST  = 2'h0;
	localparam logic [3:0] CAPT_RST  = 4'h0;
	// divide ratio codes
	localparam logic [2:0] DIV_BY1 = 3'h0;
	localparam logic [2:0] DIV_BY2 = 3'h1;
	localparam logic [2:0] DIV_BY4 = 3'h3;
endpackage

// [icdp_sref_sync.sv]
// two-stage synchroniser and rising edge detect for the timing reference
`timescale 1ns/1ps
`default_nettype none
module icdp_sref_sync (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	// reference pin and captured event
	input  wire logic sref_pin_i,
	output logic      sref_edge_o
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} icdp_sync_s;

	icdp_sync_s st_q;
	icdp_sync_s st_d;

	// meta feeds only sync; the edge compares the two settled stages
	always_comb begin
		st_d      = st_q;
		st_d.meta = sref_pin_i;
		st_d.sync = st_q.meta;
		st_d.last = st_q.sync;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sref_edge_o = st_q.sync & ~st_q.last;
endmodule // icdp_sref_sync
`default_nettype wire

// [icdp_top.sv]
// input clock divider with local and reference-driven phase control
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module icdp_top (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// timing reference pin
	input  wire logic        sref_pin_i,
	// divider outputs
	output logic             div_tick_o,
	output logic             div_clk_o,
	output logic             clk_invert_o,
	output logic      [3:0]  phase_offset_o
);
	typedef struct packed {
		logic [2:0]  ratio;
		logic [3:0]  local_ph;
		logic        auto_en;
		logic [1:0]  neg_win;
		logic [1:0]  pos_win;
		logic [3:0]  capt;
		logic [1:0]  cnt;
		logic        tick;
		logic        dclk;
		logic [31:0] rdata;
	} icdp_state_s;

	icdp_state_s st_q;
	icdp_state_s st_d;

	logic       sref_edge;
	logic       wr_acc;
	logic       rd_setup;
	logic       hit;
	logic [1:0] mask;
	logic [3:0] eff_off;
	logic [1:0] ph;
	logic [3:0] half_pos;
	logic       in_win;
	logic       accept;

	// unknown ratio codes fall back to divide by one
	function automatic logic [1:0] ratio_mask(input logic [2:0] code);
		if (code == icdp_pkg::DIV_BY2) begin
			return 2'h1;
		end else if (code == icdp_pkg::DIV_BY4) begin
			return 2'h3;
		end else begin
			return 2'h0;
		end
	endfunction

	function automatic logic addr_is(input logic [11:0] a,
		input logic [11:0] b);
		return a == b;
	endfunction

	icdp_sref_sync u_sync (
		.clk_sys_i   (clk_sys_i),
		.reset_i     (reset_i),
		.sref_pin_i  (sref_pin_i),
		.sref_edge_o (sref_edge)
	);

	assign wr_acc   = psel_i & penable_i & pwrite_i & hit;
	assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
	assign hit = addr_is(paddr_i, icdp_pkg::ADDR_RATIO) |
		addr_is(paddr_i, icdp_pkg::ADDR_PHASE) |
		addr_is(paddr_i, icdp_pkg::ADDR_SREF) |
		addr_is(paddr_i, icdp_pkg::ADDR_CAPT);

	assign mask = ratio_mask(st_q.ratio);
	// without auto adjust the local code alone sets the phase
	assign eff_off = st_q.auto_en ? 4'(st_q.capt + st_q.local_ph)
		: st_q.local_ph;
	// whole-cycle part of the delay, folded into the divide period
	assign ph = 2'(st_q.cnt + 2'h1 - eff_off[2:1]) & mask;

	// capture position after the divider edge, in half input cycles
	assign half_pos = {1'b0, st_q.cnt, 1'b0};
	// windows are only meaningful while their sum stays below the ratio
	assign in_win = (half_pos != 4'h0) &&
		((half_pos <= {2'b00, st_q.pos_win}) ||
		((({1'b0, mask, 1'b0} + 4'h2 - half_pos) & 4'hf)
		<= {2'b00, st_q.neg_win}));
	assign accept = sref_edge & st_q.auto_en & ~in_win;

	always_comb begin
		st_d      = st_q;
		st_d.cnt  = (st_q.cnt + 2'h1) & mask;
		st_d.tick = (ph == 2'h0);
		if (mask == 2'h0) begin
			st_d.dclk = 1'b1;
		end else begin
			st_d.dclk = (ph <= (mask >> 1));
		end
		// realign: store the phase seen at capture, only when enabled
		if (accept) begin
			st_d.capt = half_pos;
		end
		if (wr_acc) begin
			if (addr_is(paddr_i, icdp_pkg::ADDR_RATIO)) begin
				st_d.ratio = pwdata_i[icdp_pkg::RATIO_LSB +: 3];
			end else if (addr_is(paddr_i, icdp_pkg::ADDR_PHASE)) begin
				st_d.local_ph = pwdata_i[icdp_pkg::PHASE_LSB +: 4];
			end else if (addr_is(paddr_i, icdp_pkg::ADDR_SREF)) begin
				st_d.auto_en = pwdata_i[icdp_pkg::AUTO_BIT];
				st_d.neg_win = pwdata_i[icdp_pkg::NEG_LSB +: 2];
				st_d.pos_win = pwdata_i[icdp_pkg::POS_LSB +: 2];
			end
		end
		// read data is latched in the setup cycle so it comes from a flop
		if (rd_setup) begin
			st_d.rdata = 32'h0;
			if (addr_is(paddr_i, icdp_pkg::ADDR_RATIO)) begin
				st_d.rdata[icdp_pkg::RATIO_LSB +: 3] = st_q.ratio;
			end else if (addr_is(paddr_i, icdp_pkg::ADDR_PHASE)) begin
				st_d.rdata[icdp_pkg::PHASE_LSB +: 4] = st_q.local_ph;
			end else if (addr_is(paddr_i, icdp_pkg::ADDR_SREF)) begin
				st_d.rdata[icdp_pkg::AUTO_BIT]       = st_q.auto_en;
				st_d.rdata[icdp_pkg::NEG_LSB +: 2]   = st_q.neg_win;
				st_d.rdata[icdp_pkg::POS_LSB +: 2]   = st_q.pos_win;
			end else if (addr_is(paddr_i, icdp_pkg::ADDR_CAPT)) begin
				st_d.rdata[icdp_pkg::CAPT_LSB +: 4]  = st_q.capt;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_q          <= '0;
			st_q.ratio    <= icdp_pkg::RATIO_RST;
			st_q.local_ph <= icdp_pkg::PHASE_RST;
			st_q.auto_en  <= icdp_pkg::AUTO_RST;
			st_q.neg_win  <= icdp_pkg::SKEW_RST;
			st_q.pos_win  <= icdp_pkg::SKEW_RST;
			st_q.capt     <= icdp_pkg::CAPT_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// zero wait states; unmapped addresses answer with an error
	assign pready_o       = 1'b1;
	assign pslverr_o      = psel_i & penable_i & ~hit;
	assign prdata_o       = st_q.rdata;
	assign div_tick_o     = st_q.tick;
	assign div_clk_o      = st_q.dclk;
	// odd offset codes select the inverted input clock
	assign clk_invert_o   = eff_off[0];
	assign phase_offset_o = eff_off;

	// helper for the assertions: anything that may move the phase
	logic cfg_chg;
	assign cfg_chg = wr_acc | accept;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);

	sequence s_tick4;
		div_tick_o && mask == 2'h3 && !cfg_chg;
	endsequence

	sequence s_quiet3;
		(!cfg_chg) [*3];
	endsequence

	sequence s_steady;
		!cfg_chg;
	endsequence

	sequence s_tick2;
		div_tick_o && mask == 2'h1;
	endsequence

	AST_DIV_PERIOD: assert property (
		s_steady ##1 s_tick4 ##1 s_quiet3 |=> div_tick_o)
		else $error("divide by four tick period wrong");

	AST_RATIO_RESET: assert property (disable iff (1'b0)
		reset_i |=> mask == 2'h0 && phase_offset_o == 4'h0)
		else $error("ratio or phase not cleared by reset");

	AST_LOCAL_WRITE: assert property (
		wr_acc && paddr_i == icdp_pkg::ADDR_PHASE && !st_q.auto_en
		&& !(wr_acc && paddr_i == icdp_pkg::ADDR_SREF)
		|=> st_q.auto_en || phase_offset_o == $past(pwdata_i[3:0]))
		else $error("local phase write not applied");

	AST_INVERT: assert property (
		!st_q.auto_en |-> clk_invert_o == st_q.local_ph[0])
		else $error("half cycle not made by inversion");

	AST_NO_AUTO: assert property (
		!st_q.auto_en |=> $stable(st_q.capt))
		else $error("capture moved phase with auto adjust off");

	AST_CAPTURE: assert property (
		st_q.auto_en && sref_edge && !in_win
		|=> st_q.capt == $past(half_pos))
		else $error("captured phase not stored");

	AST_SUM: assert property (
		st_q.auto_en |-> phase_offset_o == 4'(st_q.capt + st_q.local_ph))
		else $error("effective offset is not capture plus local");

	AST_WINDOW: assert property (
		sref_edge && in_win |=> $stable(st_q.capt))
		else $error("capture inside skew window not ignored");

	AST_RSVD_READ: assert property (
		rd_setup && paddr_i == icdp_pkg::ADDR_RATIO
		|=> prdata_o[31:3] == 29'h0)
		else $error("reserved ratio bits read nonzero");

	AST_UNMAPPED: assert property (
		psel_i && penable_i && !hit |-> pslverr_o && pready_o)
		else $error("unmapped access not refused");

	AST_RATIO_WRITE: assert property (
		wr_acc && paddr_i == icdp_pkg::ADDR_RATIO
		|=> st_q.ratio == $past(pwdata_i[2:0]))
		else $error("ratio write not applied");

	AST_DIV1_TICK: assert property (
		mask == 2'h0 |=> div_tick_o && div_clk_o)
		else $error("divide by one not ticking every cycle");

	AST_DIV2_ALT: assert property (
		s_steady ##1 s_tick2 |=> !div_tick_o)
		else $error("divide by two tick not alternating");

	AST_TICK_CLK: assert property (
		div_tick_o |-> div_clk_o)
		else $error("divided clock low at phase zero");

	AST_SREF_WRITE: assert property (
		wr_acc && paddr_i == icdp_pkg::ADDR_SREF
		|=> st_q.auto_en == $past(pwdata_i[7]))
		else $error("auto adjust enable write not applied");

	AST_WIN_WRITE: assert property (
		wr_acc && paddr_i == icdp_pkg::ADDR_SREF
		|=> st_q.pos_win == $past(pwdata_i[1:0])
		&& st_q.neg_win == $past(pwdata_i[3:2]))
		else $error("skew window write not applied");

	AST_RSVD_PHASE: assert property (
		rd_setup && paddr_i == icdp_pkg::ADDR_PHASE
		|=> prdata_o[31:4] == 28'h0)
		else $error("reserved phase bits read nonzero");

	AST_RSVD_SREF: assert property (
		rd_setup && paddr_i == icdp_pkg::ADDR_SREF
		|=> prdata_o[31:8] == 24'h0 && prdata_o[6:4] == 3'h0)
		else $error("reserved control bits read nonzero");

	AST_READ_HOLD: assert property (
		!rd_setup |=> $stable(prdata_o))
		else $error("read data moved outside a read setup");

	AST_CAPT_HOLD: assert property (
		!accept |=> $stable(st_q.capt))
		else $error("captured phase moved without a capture");

	AST_NO_AUTO_OFFSET: assert property (
		!st_q.auto_en |-> phase_offset_o == st_q.local_ph)
		else $error("offset not local with auto adjust off");

	AST_UNMAPPED_WRITE: assert property (
		psel_i && penable_i && pwrite_i && !hit
		|=> $stable(st_q.ratio) && $stable(st_q.local_ph)
		&& $stable(st_q.auto_en))
		else $error("unmapped write changed a register");

	AST_EDGE_SINGLE: assert property (
		sref_edge |=> !sref_edge)
		else $error("reference edge longer than one cycle");

	AST_REF_LATENCY: assert property (
		$rose(sref_pin_i) |-> ##2 sref_edge)
		else $error("reference edge late after pin rise");
endmodule // icdp_top
`default_nettype wire

// [icdp_sref_src.sv]
// timing reference source at the far side of the divider
`timescale 1ns/1ps
`default_nettype none
module icdp_sref_src (
	// clock
	input  wire logic clk_sys_i,
	// reference pin
	output logic      sref_pin_o
);
	initial sref_pin_o = 1'b0;
	// pin rests low a few cycles so the next rise counts as a new edge
	task automatic pulse(input int hi);
		@(posedge clk_sys_i);
		sref_pin_o <= 1'b1;
		repeat (hi) @(posedge clk_sys_i);
		sref_pin_o <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask
endmodule // icdp_sref_src
`default_nettype wire

// [input_clock_divider_phase_test.sv]
// self-checking bench for the input clock divider phase block
`timescale 1ns/1ps
`default_nettype none
module input_clock_divider_phase_test;
	logic        clk_sys_i, reset_i, psel_i, penable_i, pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, sref_pin_i, div_tick_o, div_clk_o;
	logic        clk_invert_o, err;
	logic [3:0]  phase_offset_o;
	int          n_mismatch, check_count;
	icdp_top u_icdp_top (.clk_sys_i, .reset_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.sref_pin_i, .div_tick_o, .div_clk_o, .clk_invert_o,
		.phase_offset_o);
	icdp_sref_src u_icdp_sref_src (.clk_sys_i, .sref_pin_o(sref_pin_i));
	task automatic check(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		forever begin
			@(posedge clk_sys_i);
			if (pready_o === 1'b1) break;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic ticks(input logic [2:0] code, input int exp,
			input int exp_hi);
		int n, h;
		n = 0;
		h = 0;
		apb(1'b1, icdp_pkg::ADDR_RATIO, {29'h0, code});
		repeat (4) @(negedge clk_sys_i);
		repeat (8) begin
			@(negedge clk_sys_i);
			n += int'(div_tick_o === 1'b1);
			h += int'(div_clk_o === 1'b1);
		end
		check(n, exp);
		check(h, exp_hi);
	endtask
	task automatic t_reset;
		apb(1'b0, icdp_pkg::ADDR_RATIO, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, icdp_pkg::ADDR_PHASE, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, icdp_pkg::ADDR_SREF, 32'h0);
		check(rd, 32'h0);
		check({clk_invert_o, phase_offset_o}, 32'h0);
		apb(1'b0, 12'h400, 32'h0);
		check(err, 32'h1);
		check(rd, 32'h0);
	endtask
	task automatic t_local;
		for (int k = 0; k < 16; k++) begin
			apb(1'b1, icdp_pkg::ADDR_PHASE, k);
			@(negedge clk_sys_i);
			check(phase_offset_o, k);
			check(clk_invert_o, k & 1);
		end
		apb(1'b1, icdp_pkg::ADDR_PHASE, 32'hf5);
		apb(1'b0, icdp_pkg::ADDR_PHASE, 32'h0);
		check(rd, 32'h5);
		apb(1'b1, icdp_pkg::ADDR_RATIO, 32'hff);
		apb(1'b0, icdp_pkg::ADDR_RATIO, 32'h0);
		check(rd, 32'h7);
	endtask
	// a tick marks the counter equal to the whole-cycle offset
	task automatic to_tick(input int extra);
		@(negedge clk_sys_i);
		while (div_tick_o !== 1'b1) @(negedge clk_sys_i);
		repeat (extra) @(negedge clk_sys_i);
	endtask
	task automatic t_auto;
		apb(1'b1, icdp_pkg::ADDR_RATIO, 32'h3);
		u_icdp_sref_src.pulse(1);
		apb(1'b0, icdp_pkg::ADDR_CAPT, 32'h0);
		check(rd, 32'h0);
		check(phase_offset_o, 32'h5);
		// reference idle while the skew windows change
		apb(1'b1, icdp_pkg::ADDR_SREF, 32'h85);
		// counter 2 at the tick, so the synced edge meets counter 1
		to_tick(0);
		u_icdp_sref_src.pulse(3);
		apb(1'b0, icdp_pkg::ADDR_CAPT, 32'h0);
		check(rd, 32'h2);
		check(phase_offset_o, 32'h7);
		apb(1'b1, icdp_pkg::ADDR_PHASE, 32'hf);
		@(negedge clk_sys_i);
		check(phase_offset_o, 32'h1);
		check(clk_invert_o, 32'h1);
		apb(1'b1, icdp_pkg::ADDR_SREF, 32'h82);
		// edge meets counter 1 again, now inside the positive window
		to_tick(2);
		u_icdp_sref_src.pulse(1);
		apb(1'b0, icdp_pkg::ADDR_CAPT, 32'h0);
		check(rd, 32'h2);
		check(phase_offset_o, 32'h1);
		apb(1'b1, icdp_pkg::ADDR_RATIO, 32'h0);
		u_icdp_sref_src.pulse(2);
		apb(1'b0, icdp_pkg::ADDR_CAPT, 32'h0);
		check(rd, 32'h0);
		check(phase_offset_o, 32'hf);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		repeat (4000) @(posedge clk_sys_i);
		n_mismatch++;
		conclude;
	end
	initial begin
		{reset_i, psel_i, penable_i, pwrite_i} = 4'h8;
		paddr_i = 12'h0;
		pwdata_i = 32'h0;
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t_reset;
		ticks(icdp_pkg::DIV_BY1, 8, 8);
		ticks(icdp_pkg::DIV_BY2, 4, 4);
		ticks(icdp_pkg::DIV_BY4, 2, 4);
		ticks(3'h2, 8, 8);
		t_local;
		t_auto;
		conclude;
	end
endmodule // input_clock_divider_phase_test
`default_nettype wire
